// ### hw/msel_pkg.sv
// Shared constants for the memory select and digital volume switch block.
// Assumes a single 125 MHz clock; all slow timing runs off a 1 ms tick.
package msel_pkg;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int DEBOUNCE_MS   = 10;
  localparam int LONG_MS       = 1000;
  localparam int FADE_MS       = 16;
  localparam int BEEP_MS       = 100;
  localparam int DEBOUNCE_TKS  = (DEBOUNCE_MS * 1000000) / TICK_NS;
  localparam int LONG_TKS      = (LONG_MS * 1000000) / TICK_NS;
  localparam int FADE_TKS      = (FADE_MS * 1000000) / TICK_NS;
  localparam int BEEP_TKS      = (BEEP_MS * 1000000) / TICK_NS;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_POR    = 4'h1;
  localparam logic [3:0] ADDR_VOLUME = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;

  localparam int CTRL_STATIC   = 0;
  localparam int CTRL_JUMP     = 1;
  localparam int CTRL_POL1     = 2;
  localparam int CTRL_POL2     = 3;
  localparam int CTRL_BEEP     = 4;
  localparam int CTRL_LONG     = 5;
  localparam int CTRL_VALID_LO = 8;

  localparam logic [15:0] CTRL_RST   = 16'h0100;
  localparam logic [15:0] POR_RST    = 16'h0064;
  localparam logic [15:0] VOLUME_RST = 16'h0008;

  // ------------------------------------------------------------------
  // Memories and sequencer states
  // ------------------------------------------------------------------
  localparam logic [1:0] MEM_A = 2'h0;
  localparam logic [1:0] MEM_B = 2'h1;
  localparam logic [1:0] MEM_C = 2'h2;
  localparam logic [1:0] MEM_D = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_FADE_OUT = 3'h1,
    ST_BEEP     = 3'h3,
    ST_SWITCH   = 3'h2,
    ST_FADE_IN  = 3'h6
  } msel_state_e;

endpackage

// ### hw/msel_switch_logic.sv
// Memory select and digital volume switch logic.
// Assumes raw switch pins arrive asynchronously and the register port is
// driven by same-clock logic.
`timescale 1ns/100ps
module msel_switch_logic
  import msel_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int VOL_W    = 5
)
(
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic             gain_up_input_i,
  input  wire logic             gain_down_input_i,
  input  wire logic             select_input_first_i,
  input  wire logic             select_input_second_i,
  input  wire logic [3:0]       reg_addr_i,
  input  wire logic [15:0]      reg_wdata_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  output logic      [15:0]      reg_rdata_o,
  output logic      [1:0]       memory_sel_o,
  output logic                  gain_up_step_o,
  output logic                  gain_down_step_o,
  output logic      [VOL_W-1:0] volume_level_o,
  output logic                  fade_out_o,
  output logic                  fade_in_o,
  output logic                  beep_req_o,
  output logic                  audio_enable_o
);

  localparam int TCW = $clog2(TICK_CYC + 1);

  // ------------------------------------------------------------------
  // Millisecond tick
  // ------------------------------------------------------------------
  logic [TCW-1:0] tick_cnt_q;
  logic           tick_q;

  // Every slow timer in the block advances on this one-cycle enable.
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end
    else
    begin
      tick_q     <= (tick_cnt_q == TCW'(TICK_CYC - 1));
      tick_cnt_q <= (tick_cnt_q == TCW'(TICK_CYC - 1)) ? '0 : tick_cnt_q + 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Input synchronisers and debouncers
  // ------------------------------------------------------------------
  logic [3:0] raw;
  logic [3:0] sync0_q;
  logic [3:0] sync1_q;
  logic [3:0] db_q;

  assign raw = {select_input_second_i, select_input_first_i,
                gain_down_input_i, gain_up_input_i};

  // A level must hold steady for the whole window before it is accepted,
  // so contact bounce yields one clean edge per press.
  for (genvar g = 0; g < 4; g++)
  begin : g_deb
    logic [3:0] cnt_q;
    always_ff @(posedge clock_i)
    begin
      if (!rst_n_i)
      begin
        sync0_q[g] <= 1'b0;
        sync1_q[g] <= 1'b0;
        db_q[g]    <= 1'b0;
        cnt_q      <= '0;
      end
      else
      begin
        sync0_q[g] <= raw[g];
        sync1_q[g] <= sync0_q[g];
        if (sync1_q[g] == db_q[g])
          cnt_q <= '0;
        else if (tick_q && cnt_q == 4'(DEBOUNCE_TKS - 1))
        begin
          db_q[g] <= sync1_q[g];
          cnt_q   <= '0;
        end
        else if (tick_q)
          cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [15:0]      ctrl_q;
  logic [15:0]      por_q;
  logic [VOL_W-1:0] vol_q;
  logic             lock_q;
  logic [15:0]      rdata_q;
  logic [15:0]      status;
  logic             wr_ctrl;
  logic             wr_por;
  logic             acc_vol;
  logic             is_static;
  logic             is_jump;
  logic [3:0]       vm;
  logic             s1;
  logic             s2;
  logic             btn_up;
  logic             btn_dn;

  assign wr_ctrl   = reg_wr_i && reg_addr_i == ADDR_CTRL;
  assign wr_por    = reg_wr_i && reg_addr_i == ADDR_POR;
  assign acc_vol   = (reg_wr_i || reg_rd_i) && reg_addr_i == ADDR_VOLUME;
  assign is_static = ctrl_q[CTRL_STATIC];
  assign is_jump   = ctrl_q[CTRL_JUMP];
  assign vm        = ctrl_q[CTRL_VALID_LO +: 4] | 4'h1;
  // A set polarity bit inverts the select pin so that closed reads as one on pull-up wiring.
  assign s1        = db_q[2] ^ ctrl_q[CTRL_POL1];
  assign s2        = db_q[3] ^ ctrl_q[CTRL_POL2];
  assign btn_up    = db_q[0];
  assign btn_dn    = db_q[1];

  // Configuration and delay registers; any volume access trips the lock.
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_q <= CTRL_RST;
      por_q  <= POR_RST;
      lock_q <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= reg_wdata_i;
      if (wr_por)
        por_q <= reg_wdata_i;
      if (acc_vol)
        lock_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Power-on delay
  // ------------------------------------------------------------------
  logic [15:0] por_cnt_q;
  logic        audio_en_q;

  // Audio stays off, and buttons dead, until the delay in ms has passed.
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      por_cnt_q  <= '0;
      audio_en_q <= 1'b0;
    end
    else if (!audio_en_q && tick_q)
    begin
      por_cnt_q  <= por_cnt_q + 16'h1;
      audio_en_q <= (por_cnt_q >= por_q);
    end
  end

  // ------------------------------------------------------------------
  // Press classification
  // ------------------------------------------------------------------
  logic       pressed;
  logic       prev_q;
  logic       which_q;
  logic [9:0] hold_q;
  logic       long_en;
  logic       live;
  logic       ev_up;
  logic       ev_dn;
  logic       long_hit;

  assign pressed  = btn_up | btn_dn;
  assign long_en  = ctrl_q[CTRL_LONG];
  assign live     = audio_en_q && !lock_q;
  // Without long-press use a step fires on closure; with it, on a short
  // release, trading response time for a second function per button.
  assign ev_up    = live && (long_en
                    ? (!pressed && prev_q && !which_q && hold_q < 10'(LONG_TKS))
                    : (btn_up && !prev_q));
  assign ev_dn    = live && (long_en
                    ? (!pressed && prev_q && which_q && hold_q < 10'(LONG_TKS))
                    : (btn_dn && !btn_up && !prev_q));
  assign long_hit = live && long_en && pressed && tick_q
                    && hold_q == 10'(LONG_TKS - 1);

  // Hold timer for the button that opened the press.
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      prev_q  <= 1'b0;
      which_q <= 1'b0;
      hold_q  <= '0;
    end
    else
    begin
      prev_q <= pressed;
      if (pressed && !prev_q)
      begin
        which_q <= !btn_up;
        hold_q  <= '0;
      end
      else if (pressed && tick_q && hold_q < 10'(LONG_TKS))
        hold_q <= hold_q + 10'h1;
    end
  end

  // ------------------------------------------------------------------
  // Volume
  // ------------------------------------------------------------------
  logic up_step_q;
  logic dn_step_q;

  // Steps saturate; a pulse is issued when a step is due, even if a same-cycle volume write sets the level instead.
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      vol_q     <= VOL_W'(VOLUME_RST);
      up_step_q <= 1'b0;
      dn_step_q <= 1'b0;
    end
    else
    begin
      up_step_q <= ev_up && vol_q != '1;
      dn_step_q <= ev_dn && vol_q != '0;
      if (reg_wr_i && reg_addr_i == ADDR_VOLUME)
        vol_q <= reg_wdata_i[VOL_W-1:0];
      else if (ev_up && vol_q != '1)
        vol_q <= vol_q + 1'b1;
      else if (ev_dn && vol_q != '0)
        vol_q <= vol_q - 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Memory selection
  // ------------------------------------------------------------------
  function automatic logic [1:0] next_mem(input logic [1:0] cur,
                                          input logic [3:0] v,
                                          input logic       no_d);
    logic [1:0] c;
    logic [1:0] r;
    logic       f;
    c = cur;
    r = MEM_A;
    f = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      c = c + 2'h1;
      if (!f && v[c] && !(no_d && c == MEM_D))
      begin
        r = c;
        f = 1'b1;
      end
    end
    return r;
  endfunction

  logic [1:0] mom_q;
  logic       s1_prev_q;
  logic       adv;
  logic [1:0] fb_mom;
  logic [1:0] fb_d;
  logic [1:0] fb_idx;
  logic [1:0] fb_b;
  logic [1:0] want;

  assign fb_mom = vm[mom_q] ? mom_q : MEM_A;
  assign fb_d   = vm[3] ? MEM_D : MEM_A;
  assign fb_idx = vm[{s2, s1}] ? {s2, s1} : MEM_A;
  assign fb_b   = vm[1] ? MEM_B : MEM_A;
  // Presses count only in momentary modes, never with the jump closed.
  assign adv    = audio_en_q && !is_static && !(is_jump && s2)
                  && ((s1 && !s1_prev_q) || long_hit);
  // Static modes read the debounced levels directly, so two switches that
  // settle apart pass through the memory in between.
  assign want   = is_static
                  ? (is_jump ? (s2 ? fb_d : (s1 ? fb_b : MEM_A))
                             : fb_idx)
                  : ((is_jump && s2) ? fb_d : fb_mom);

  // The momentary choice is kept aside while the jump holds D.
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      mom_q     <= MEM_A;
      s1_prev_q <= 1'b0;
    end
    else
    begin
      s1_prev_q <= s1;
      if (adv)
        mom_q <= next_mem(fb_mom, vm, is_jump);
    end
  end

  // ------------------------------------------------------------------
  // Change sequencer
  // ------------------------------------------------------------------
  msel_state_e state_q;
  msel_state_e state_d;
  logic [6:0]  tmr_q;
  logic        tmr_done;
  logic [1:0]  active_q;

  assign tmr_done = tick_q && tmr_q == 7'h0;

  // Fade out, optional beep, switch, fade in.
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:     if (audio_en_q && want != active_q) state_d = ST_FADE_OUT;
      ST_FADE_OUT: if (tmr_done)
                     state_d = ctrl_q[CTRL_BEEP] ? ST_BEEP : ST_SWITCH;
      ST_BEEP:     if (tmr_done) state_d = ST_SWITCH;
      ST_SWITCH:   state_d = ST_FADE_IN;
      ST_FADE_IN:  if (tmr_done) state_d = ST_IDLE;
      default:     state_d = ST_IDLE;
    endcase
  end

  // Before audio starts the memory follows the switches silently.
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      state_q  <= ST_IDLE;
      tmr_q    <= '0;
      active_q <= MEM_A;
    end
    else
    begin
      state_q <= state_d;
      if (state_d != state_q)
        tmr_q <= (state_d == ST_BEEP) ? 7'(BEEP_TKS - 1) : 7'(FADE_TKS - 1);
      else if (tick_q && tmr_q != 7'h0)
        tmr_q <= tmr_q - 7'h1;
      if (!audio_en_q || state_q == ST_SWITCH)
        active_q <= want;
    end
  end

  // ------------------------------------------------------------------
  // Outputs and read data
  // ------------------------------------------------------------------
  assign status = {6'h0, want, 1'b0, s2, s1, lock_q, audio_en_q,
                   state_q != ST_IDLE, active_q};

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      rdata_q    <= '0;
      fade_out_o <= 1'b0;
      fade_in_o  <= 1'b0;
      beep_req_o <= 1'b0;
    end
    else
    begin
      rdata_q    <= '0;
      if (reg_rd_i)
        case (reg_addr_i)
          ADDR_CTRL:   rdata_q <= ctrl_q;
          ADDR_POR:    rdata_q <= por_q;
          ADDR_VOLUME: rdata_q <= 16'(vol_q);
          ADDR_STATUS: rdata_q <= status;
          default:     rdata_q <= '0;
        endcase
      fade_out_o <= state_d == ST_FADE_OUT || state_d == ST_BEEP
                    || state_d == ST_SWITCH;
      fade_in_o  <= state_d == ST_FADE_IN;
      beep_req_o <= state_d == ST_BEEP;
    end
  end

  assign reg_rdata_o      = rdata_q;
  assign memory_sel_o     = active_q;
  assign gain_up_step_o   = up_step_q;
  assign gain_down_step_o = dn_step_q;
  assign volume_level_o   = vol_q;
  assign audio_enable_o   = audio_en_q;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  a_lock_no_steps: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    lock_q |=> !up_step_q && !dn_step_q)
    else $error("Volume step issued while locked.");

  a_por_ignores: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !audio_en_q |=> !up_step_q && !dn_step_q && $stable(mom_q))
    else $error("Press acted on during power-on delay.");

  a_up_step_raise: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    up_step_q |-> (vol_q - $past(vol_q)) == VOL_W'(1))
    else $error("Up step did not raise the level by one.");

  a_want_valid: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    vm[want])
    else $error("Wanted memory is not valid.");

  a_switch_then_in: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    state_q == ST_SWITCH |=> state_q == ST_FADE_IN && fade_in_o && !fade_out_o)
    else $error("Switch not followed by fade in.");

  a_change_in_switch: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $past(audio_en_q) && active_q != $past(active_q) |-> $past(state_q) == ST_SWITCH)
    else $error("Memory changed outside the switch step.");

  a_mode2_jump_d: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !is_static && is_jump && s2 && vm[3] && audio_en_q && state_q == ST_IDLE
    && active_q != MEM_D |=> state_q == ST_FADE_OUT)
    else $error("Jump to D did not start a change.");

  a_mode3_decode: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    is_static && !is_jump && s1 && s2 |-> want == (vm[3] ? MEM_D : MEM_A))
    else $error("Binary decode of both closed is wrong.");

  a_mode4_open: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    is_static && is_jump && !s2 && !s1 |-> want == MEM_A)
    else $error("Mode four with both open is not A.");

endmodule

// ### testbench/msel_switch_model.sv
// Model of one user switch or button as it reaches a device pin.
// Assumes the bench commands the closure and the wiring polarity.
`timescale 1ns/100ps
module msel_switch_model (
  input  wire logic       clock_i,
  input  wire logic       closed_i,
  input  wire logic       pull_up_i,
  input  wire logic [3:0] bounce_i,
  output logic            pin_o
);
  logic       settled_q = 1'b0;
  logic [3:0] left_q    = 4'h0;

  // Each change of contact chatters for bounce_i cycles before it settles.
  always @(posedge clock_i)
  begin
    if (closed_i != settled_q)
    begin
      settled_q <= closed_i;
      left_q    <= bounce_i;
    end
    else if (left_q != 4'h0)
      left_q <= left_q - 4'h1;
  end

  // A pull-up wiring reads low when closed, so the level is inverted.
  assign pin_o = ((left_q != 4'h0) ? left_q[0] : settled_q) ^ pull_up_i;
endmodule

// ### testbench/msel_switch_logic_tb.sv
// Self-checking bench for the memory select switch logic.
// Assumes the shared package and a scaled tick of four clock cycles.
`timescale 1ns/100ps
module msel_switch_logic_tb
  import msel_pkg::*;
;
  // ------------------------------------------------------------------
  // Timing and signals
  // ------------------------------------------------------------------
  localparam int TICK   = 4;
  localparam int HOLD   = (DEBOUNCE_TKS + 8) * TICK + 16;
  localparam int SETTLE = (DEBOUNCE_TKS + 2 * FADE_TKS + BEEP_TKS + 12) * TICK;
  localparam int LIMIT  = 40000;

  logic        clock;
  logic        rst_n;
  logic [3:0]  closed;
  logic        pol1;
  logic        pol2;
  logic [3:0]  bounce;
  logic [3:0]  pins;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] rdata;
  logic [1:0]  mem;
  logic        up_step;
  logic        dn_step;
  logic [4:0]  vol;
  logic        fade_out;
  logic        fade_in;
  logic        beep;
  logic        audio;
  logic [15:0] rd_val;
  logic [3:0]  pull;
  int          failures;
  int          samples_checked;
  int          cycles;
  int          ups;
  int          dns;
  int          fades;
  int          beeps;
  int          exp_mem;
  int          f0;
  int          b0;
  int          u0;
  int          fins;
  int          n0;
  logic        fo_q;
  logic        bp_q;
  logic        fi_q;

  // Buttons are wired to pull-down; the select inputs follow the bench.
  assign pull = {pol2, pol1, 2'b00};

  for (genvar g = 0; g < 4; g++)
  begin : g_sw
    msel_switch_model i_msel_switch_model (
      .clock_i   (clock),
      .closed_i  (closed[g]),
      .pull_up_i (pull[g]),
      .bounce_i  (bounce),
      .pin_o     (pins[g])
    );
  end

  msel_switch_logic #(.TICK_CYC(TICK)) i_msel_switch_logic (
    .clock_i               (clock),
    .rst_n_i               (rst_n),
    .gain_up_input_i       (pins[0]),
    .gain_down_input_i     (pins[1]),
    .select_input_first_i  (pins[2]),
    .select_input_second_i (pins[3]),
    .reg_addr_i            (reg_addr),
    .reg_wdata_i           (reg_wdata),
    .reg_wr_i              (reg_wr),
    .reg_rd_i              (reg_rd),
    .reg_rdata_o           (rdata),
    .memory_sel_o          (mem),
    .gain_up_step_o        (up_step),
    .gain_down_step_o      (dn_step),
    .volume_level_o        (vol),
    .fade_out_o            (fade_out),
    .fade_in_o             (fade_in),
    .beep_req_o            (beep),
    .audio_enable_o        (audio)
  );

  // The clock toggles every 4 ns, giving a period of 8 ns.
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Event counters and the hang guard; a stuck run is a failure.
  always @(posedge clock)
  begin
    cycles++;
    if (up_step === 1'b1)
      ups++;
    if (dn_step === 1'b1)
      dns++;
    // Rising edges are found against the level seen one clock earlier.
    if (fade_out === 1'b1 && fo_q !== 1'b1)
      fades++;
    if (beep === 1'b1 && bp_q !== 1'b1)
      beeps++;
    if (fade_in === 1'b1 && fi_q !== 1'b1)
      fins++;
    fo_q <= fade_out;
    bp_q <= beep;
    fi_q <= fade_in;
    if (cycles == LIMIT)
    begin
      failures++;
      test_done();
    end
  end

  // ------------------------------------------------------------------
  // Reference model and tasks
  // ------------------------------------------------------------------
  // Next valid memory after cur, optionally never landing on D.
  function automatic int next_valid(input int cur, input logic [3:0] m, input logic no_d);
    int n;
    for (int k = 1; k < 5; k++)
    begin
      n = (cur + k) % 4;
      if (m[n] && !(no_d && n == 3))
        return n;
    end
    return 0;
  endfunction

  // Memory wanted by the static switches; an invalid choice falls back to A.
  function automatic logic [1:0] static_mem(input logic jmp, input logic f, input logic s,
                                            input logic [3:0] m);
    logic [1:0] w;
    w = jmp ? (s ? MEM_D : {1'b0, f}) : {s, f};
    return m[w] ? w : MEM_A;
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    if (failures == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Waits are closed on a falling edge so outputs have settled.
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    @(negedge clock);
    d = rdata;
  endtask

  task automatic press(input int w, input int n);
    @(posedge clock);
    bounce    <= 4'($urandom_range(15, 1));
    closed[w] <= 1'b1;
    repeat (n) @(posedge clock);
    closed[w] <= 1'b0;
    wait_cyc(SETTLE);
  endtask

  task automatic set_sw(input logic f, input logic s);
    @(posedge clock);
    bounce    <= 4'($urandom_range(15, 1));
    closed[2] <= f;
    closed[3] <= s;
    wait_cyc(SETTLE);
  endtask

  task automatic do_reset();
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    wait_cyc(1);
  endtask

  task automatic wait_audio();
    for (int i = 0; i < 2000 && audio !== 1'b1; i++)
      @(posedge clock);
    wait_cyc(1);
    check("audio", 16'(audio), 16'h1);
  endtask

  // Reset with a given setting and switch positions, then configure.
  task automatic start_mode(input logic [15:0] c, input logic f, input logic s, input logic go);
    @(posedge clock);
    pol1      <= c[CTRL_POL1];
    pol2      <= c[CTRL_POL2];
    closed[2] <= f;
    closed[3] <= s;
    do_reset();
    reg_write(ADDR_CTRL, c);
    if (go)
      wait_audio();
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial
  begin
    {rst_n, closed, pol1, pol2, bounce, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    void'($urandom(32'h41a20026));
    do_reset();
    check("mem", 16'(mem), 16'(MEM_A));
    check("vol", 16'(vol), VOLUME_RST);
    reg_read(ADDR_CTRL, rd_val);
    check("ctrl", rd_val, CTRL_RST);
    reg_read(ADDR_POR, rd_val);
    check("por", rd_val, POR_RST);
    reg_read(4'hf, rd_val);
    check("unmapped", rd_val, 16'h0000);
    // A press during the power-on delay must be ignored.
    @(posedge clock);
    closed[0] <= 1'b1;
    repeat (HOLD) @(posedge clock);
    closed[0] <= 1'b0;
    wait_cyc(HOLD);
    check("early", 16'(ups), 16'h0);
    wait_audio();
    press(0, HOLD);
    check("up", 16'(ups), 16'h1);
    check("vol up", 16'(vol), 16'h9);
    press(1, HOLD);
    check("down", 16'(dns), 16'h1);
    check("vol dn", 16'(vol), VOLUME_RST);
    // Mode 1 with C invalid: every press fades, beeps and advances.
    start_mode(16'h0b10, 1'b0, 1'b0, 1'b1);
    exp_mem = 0;
    for (int i = 0; i < 4; i++)
    begin
      f0 = fades;
      b0 = beeps;
      n0 = fins;
      press(2, HOLD);
      exp_mem = next_valid(exp_mem, 4'hb, 1'b0);
      check("m1", 16'(mem), 16'(exp_mem));
      check("m1 fade", 16'(fades - f0), 16'h1);
      check("m1 fade in", 16'(fins - n0), 16'h1);
      check("m1 beep", 16'(beeps - b0), 16'h1);
    end
    // Long hold advances memory without a step; a short one steps.
    reg_write(ADDR_CTRL, 16'h0b30);
    u0 = ups;
    press(0, (LONG_TKS + DEBOUNCE_TKS + 8) * TICK);
    check("long", 16'(mem), 16'(next_valid(exp_mem, 4'hb, 1'b0)));
    check("long step", 16'(ups - u0), 16'h0);
    press(0, HOLD);
    check("short", 16'(ups - u0), 16'h1);
    // Mode 2: jump to D and return, presses ignored meanwhile.
    start_mode(16'h0f12, 1'b0, 1'b0, 1'b1);
    press(2, HOLD);
    check("m2 b", 16'(mem), 16'(MEM_B));
    set_sw(1'b0, 1'b1);
    check("m2 d", 16'(mem), 16'(MEM_D));
    f0 = fades;
    b0 = beeps;
    press(2, HOLD);
    check("m2 held", 16'(mem), 16'(MEM_D));
    check("m2 quiet", 16'(beeps - b0 + fades - f0), 16'h0);
    set_sw(1'b0, 1'b0);
    check("m2 back", 16'(mem), 16'(MEM_B));
    press(2, HOLD);
    press(2, HOLD);
    check("m2 wrap", 16'(mem), 16'(next_valid(2, 4'hf, 1'b1)));
    // Mode 3 on pull-up wiring with C invalid, binary decode.
    start_mode(16'h0b0d, 1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      set_sw(i[0], i[1]);
      check("m3", 16'(mem), 16'(static_mem(1'b0, i[0], i[1], 4'hb)));
    end
    // Mode 4: B, then D, then the first opens under the closed second (no change), then A.
    start_mode(16'h0f03, 1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      f0 = fades;
      set_sw(!i[1], i[0] ^ i[1]);
      check("m4", 16'(mem), 16'(static_mem(1'b1, !i[1], i[0] ^ i[1], 4'hf)));
      check("m4 fade", 16'(fades - f0), 16'(i == 2 ? 0 : 1));
    end
    // Static start in the selected memory, then the software lock.
    start_mode(16'h0f01, 1'b1, 1'b1, 1'b0);
    wait_cyc(HOLD);
    check("start", 16'(mem), 16'(MEM_D));
    check("por off", 16'(audio), 16'h0);
    wait_audio();
    reg_read(ADDR_VOLUME, rd_val);
    check("vol rd", rd_val, VOLUME_RST);
    u0 = ups;
    press(0, HOLD);
    check("locked", 16'(ups - u0), 16'h0);
    check("vol kept", 16'(vol), VOLUME_RST);
    reg_write(ADDR_VOLUME, 16'h0015);
    wait_cyc(1);
    check("vol wr", 16'(vol), 16'h0015);
    reg_read(ADDR_STATUS, rd_val);
    check("status", rd_val, 16'h037b);
    test_done();
  end
endmodule
